// >>> port_pin_function_mux.sv
// Port pin function multiplexer: control bits, port latches and pin routing.
`timescale 1ns/1ns
`include "pin_mux_defines.svh"

// Behaviour
// - Analog, digital input or output per control bits
// - Redirection bits move buzzer, timer, interrupts
// - Option bit selects reset or key-return input
// - Input bits: write latch, read pin level
// - Bit write reads, modifies, writes whole byte
// - Untargeted input bits get sampled pin level
// - Input pins keep output buffers disabled
// - Redirected functions appear only when selected
module port_pin_function_mux
    import pin_mux_pkg::*;
(
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RESET,
    // Configuration byte, sampled while reset is held.
    input wire logic [7:0] OPTION_BYTE,
    // Port control bits.
    input wire logic [7:0] DIRECTION_SELECT_P0,
    input wire logic [1:0] DIRECTION_SELECT_P4,
    input wire logic [7:0] ANALOG_DIGITAL_SELECT,
    input wire logic OPEN_DRAIN_SELECT,
    input wire logic [7:0] PIN_REDIRECT_REG,
    // Port register write.
    input wire logic WR_EN,
    input wire logic [1:0] WR_PORT,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_BIT_OP,
    input wire logic [2:0] WR_BIT_SEL,
    input wire logic WR_BIT_VAL,
    // Port register read.
    input wire logic [1:0] RD_PORT,
    output logic [7:0] RD_DATA,
    // Peripheral outputs to be routed.
    input wire logic CLOCK_BUZZER_OUT,
    input wire logic TIMER_OUT_CH1,
    input wire logic TIMER_OUT_CH2,
    input wire logic TIMER_OUT_CH3,
    // Peripheral inputs after routing.
    output logic TIMER_IN_CH1,
    output logic EXT_IRQ_2,
    output logic EXT_IRQ_3,
    output logic KEY_RETURN_1,
    output logic EXT_RESET_REQ,
    output logic [7:0] ANALOG_IN_EN,
    // Package pins.
    input wire logic [7:0] PIN_IN_P0,
    input wire logic [1:0] PIN_IN_P4,
    input wire logic [2:0] PIN_IN_P12,
    input wire logic PIN_IN_P137,
    output logic [7:0] PIN_OUT_P0,
    output logic [7:0] PIN_OE_P0,
    output logic [1:0] PIN_OUT_P4,
    output logic [1:0] PIN_OE_P4
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************

    logic [13:0] pins_sync;
    logic [7:0] p0_pin;
    logic [1:0] p4_pin;
    logic p121_pin;
    logic p122_pin;
    logic p125_pin;
    logic p137_pin;

    pin_sync2 #(.WIDTH(14)) u_sync (
        .clk(SYS_CLK),
        .rst(RESET),
        .async_in({PIN_IN_P137, PIN_IN_P12, PIN_IN_P4, PIN_IN_P0}),
        .sync_out(pins_sync)
    );

    // Splits the synchronised bus into named pin levels.
    assign p0_pin = pins_sync[7:0];
    assign p4_pin = pins_sync[9:8];
    assign p121_pin = pins_sync[10];
    assign p122_pin = pins_sync[11];
    assign p125_pin = pins_sync[12];
    assign p137_pin = pins_sync[13];

    // ****************************************************************
    // Helper
    // ****************************************************************

    // Value seen when a port register is read: pin for inputs, latch for outputs.
    function automatic logic [7:0] port_value(input logic [7:0] latch,
                                              input logic [7:0] pin,
                                              input logic [7:0] dir);
        port_value = (dir & pin) | (~dir & latch);
    endfunction : port_value

    // ****************************************************************
    // Control registers
    // ****************************************************************

    logic reset_pin_select_q;
    logic [7:0] dir_p0_q;
    logic [1:0] dir_p4_q;
    logic [7:0] ana_q;
    logic od_q;
    logic [7:0] redir_q;

    // Captures the reset-pin select bit of the configuration byte during reset.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            reset_pin_select_q <= OPTION_BYTE[`RESET_PIN_SEL_BIT];
        end
    end

    // Holds the direction, analog, open-drain and redirection bits.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            dir_p0_q <= `DIR_RESET_P0;
            dir_p4_q <= `DIR_RESET_P4;
            ana_q <= `ANA_RESET_P0;
            od_q <= `OD_RESET;
            redir_q <= `REDIR_RESET;
        end else begin
            dir_p0_q <= DIRECTION_SELECT_P0;
            dir_p4_q <= DIRECTION_SELECT_P4;
            ana_q <= ANALOG_DIGITAL_SELECT;
            od_q <= OPEN_DRAIN_SELECT;
            redir_q <= PIN_REDIRECT_REG;
        end
    end

    // ****************************************************************
    // Output latches
    // ****************************************************************

    logic [7:0] latch_p0_q;
    logic [1:0] latch_p4_q;
    logic [7:0] rd_p0;
    logic [7:0] rd_p4;
    logic [7:0] wr_byte;
    logic [7:0] rmw_base;

    // Current read values of the two writable ports.
    assign rd_p0 = port_value(latch_p0_q, p0_pin, dir_p0_q);
    assign rd_p4 = port_value({6'h00, latch_p4_q}, {6'h00, p4_pin}, {6'h00, dir_p4_q});

    // Forms the byte to write: whole byte, or read value with one bit changed.
    always_comb begin
        rmw_base = (port_sel_t'(WR_PORT) == PSEL_P4) ? rd_p4 : rd_p0;
        wr_byte = WR_DATA;
        if (WR_BIT_OP) begin
            wr_byte = rmw_base;
            wr_byte[WR_BIT_SEL] = WR_BIT_VAL;
        end
    end

    // Writes always reach the latch, whatever the direction of the bit.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            latch_p0_q <= `LATCH_RESET_P0;
            latch_p4_q <= `LATCH_RESET_P4;
        end else if (WR_EN) begin
            if (port_sel_t'(WR_PORT) == PSEL_P0) begin
                latch_p0_q <= wr_byte;
            end
            if (port_sel_t'(WR_PORT) == PSEL_P4) begin
                latch_p4_q <= wr_byte[1:0];
            end
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************

    logic [7:0] rd_d;

    // Selects the read value of the addressed port; other bits read zero.
    always_comb begin
        rd_d = 8'h00;
        case (port_sel_t'(RD_PORT))
            PSEL_P0: rd_d = rd_p0;
            PSEL_P4: rd_d = rd_p4;
            PSEL_P12: begin
                rd_d[`P12_BIT_121] = p121_pin;
                rd_d[`P12_BIT_122] = p122_pin;
                rd_d[`P12_BIT_125] = p125_pin & ~reset_pin_select_q;
            end
            PSEL_P13: rd_d[`P13_BIT_137] = p137_pin;
            default: rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            RD_DATA <= 8'h00;
        end else begin
            RD_DATA <= rd_d;
        end
    end

    // ****************************************************************
    // Pin output routing
    // ****************************************************************

    logic [7:0] p0_out_d;
    logic [7:0] p0_oe_d;
    logic [1:0] p4_out_d;
    logic [1:0] p4_oe_d;
    logic buzz_on_p40;
    logic tmr1_on_p40;

    assign buzz_on_p40 = redir_q[`REDIR_BUZZER_BIT];
    assign tmr1_on_p40 = redir_q[`REDIR_TIMER1_BIT];

    // Ors idle-low alternate outputs onto the latch; drives only output-mode pins.
    always_comb begin
        p0_out_d = latch_p0_q;
        p0_out_d[`P0_BUZZER_PIN] = latch_p0_q[`P0_BUZZER_PIN] | (CLOCK_BUZZER_OUT & ~buzz_on_p40);
        p0_out_d[`P0_TIMER1_PIN] = latch_p0_q[`P0_TIMER1_PIN] | (TIMER_OUT_CH1 & ~tmr1_on_p40);
        p0_out_d[`P0_TIMER2_PIN] = latch_p0_q[`P0_TIMER2_PIN] | TIMER_OUT_CH2;
        p0_out_d[`P0_TIMER3_PIN] = latch_p0_q[`P0_TIMER3_PIN] | TIMER_OUT_CH3;
        p0_oe_d = ~dir_p0_q;
        // Open-drain on the first pin only sinks, never drives high.
        p0_oe_d[0] = ~dir_p0_q[0] & ~(od_q & p0_out_d[0]);
        p4_out_d = latch_p4_q;
        p4_out_d[0] = latch_p4_q[0] | (CLOCK_BUZZER_OUT & buzz_on_p40)
                      | (TIMER_OUT_CH1 & tmr1_on_p40);
        p4_oe_d = ~dir_p4_q;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            PIN_OUT_P0 <= 8'h00;
            PIN_OE_P0 <= 8'h00;
            PIN_OUT_P4 <= 2'h0;
            PIN_OE_P4 <= 2'h0;
        end else begin
            PIN_OUT_P0 <= p0_out_d;
            PIN_OE_P0 <= p0_oe_d;
            PIN_OUT_P4 <= p4_out_d;
            PIN_OE_P4 <= p4_oe_d;
        end
    end

    // ****************************************************************
    // Peripheral input routing
    // ****************************************************************

    logic [7:0] p0_dig_in;
    logic [1:0] sync_fill_q;

    // Digital input path is live only with direction 1 and analog select 0.
    assign p0_dig_in = p0_pin & dir_p0_q & ~ana_q;

    // Marks the synchroniser as refilled two edges after reset.
    // Its cleared stages would otherwise look like a low reset pin and request a reset.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            sync_fill_q <= 2'h0;
        end else begin
            sync_fill_q <= {sync_fill_q[0], 1'h1};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            TIMER_IN_CH1 <= 1'b0;
            EXT_IRQ_2 <= 1'b0;
            EXT_IRQ_3 <= 1'b0;
            KEY_RETURN_1 <= 1'b0;
            EXT_RESET_REQ <= 1'b0;
            ANALOG_IN_EN <= 8'h00;
        end else begin
            TIMER_IN_CH1 <= tmr1_on_p40 ? (p4_pin[0] & dir_p4_q[0])
                                        : p0_dig_in[`P0_TIMER1_PIN];
            EXT_IRQ_2 <= redir_q[`REDIR_IRQ2_BIT] ? p122_pin
                                                  : (p4_pin[1] & dir_p4_q[1]);
            EXT_IRQ_3 <= redir_q[`REDIR_IRQ3_BIT] ? p121_pin
                                                  : p0_dig_in[`P0_IRQ3_PIN];
            KEY_RETURN_1 <= ~reset_pin_select_q & p125_pin;
            EXT_RESET_REQ <= sync_fill_q[1] & reset_pin_select_q & ~p125_pin;
            ANALOG_IN_EN <= ana_q & dir_p0_q;
        end
    end

endmodule : port_pin_function_mux

// >>> pin_mux_defines.svh
// Constants for the port pin function multiplexer.
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// Redirection register bit positions.
`define REDIR_BUZZER_BIT 3'd0
`define REDIR_TIMER1_BIT 3'd1
`define REDIR_IRQ2_BIT 3'd3
`define REDIR_IRQ3_BIT 3'd4

// Configuration byte address and reset-pin select bit position.
`define OPTION_BYTE_ADDR 20'h000C1
`define RESET_PIN_SEL_BIT 3'd4

// Reset values of the port control registers.
`define DIR_RESET_P0 8'hFF
`define DIR_RESET_P4 2'h3
`define ANA_RESET_P0 8'hFF
`define LATCH_RESET_P0 8'h00
`define LATCH_RESET_P4 2'h0
`define REDIR_RESET 8'h00
`define OD_RESET 1'b0

// Port 0 pin positions carrying alternate outputs and inputs.
`define P0_BUZZER_PIN 3'd2
`define P0_TIMER1_PIN 3'd4
`define P0_TIMER2_PIN 3'd5
`define P0_IRQ3_PIN 3'd6
`define P0_TIMER3_PIN 3'd7

// Bit positions of the input-only ports in their port registers.
`define P12_BIT_121 3'd1
`define P12_BIT_122 3'd2
`define P12_BIT_125 3'd5
`define P13_BIT_137 3'd7

`endif

// >>> pin_mux_pkg.sv
// Types shared by the port pin function multiplexer.
package pin_mux_pkg;

    // Port register selected by a read or write.
    typedef enum logic [1:0] {
        PSEL_P0,
        PSEL_P4,
        PSEL_P12,
        PSEL_P13
    } port_sel_t;

endpackage : pin_mux_pkg

// >>> pin_sync2.sv
// Two flip-flop synchroniser for pin levels.
`timescale 1ns/1ns

module pin_sync2 #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Asynchronous level in, synchronised level out.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : pin_sync2

// >>> pin_mux_properties.sv
// Concurrent checks on the ports of the port pin function multiplexer.
`timescale 1ns/1ns

module pin_mux_properties (
    // Clock, reset and controls.
    input wire logic SYS_CLK, RESET, WR_EN, WR_BIT_OP,
    input wire logic CLOCK_BUZZER_OUT, TIMER_OUT_CH1, TIMER_OUT_CH2, TIMER_OUT_CH3,
    input wire logic [7:0] OPTION_BYTE, DIRECTION_SELECT_P0, ANALOG_DIGITAL_SELECT,
    input wire logic [7:0] PIN_REDIRECT_REG, WR_DATA,
    input wire logic [1:0] DIRECTION_SELECT_P4, WR_PORT, RD_PORT,
    // Observed pins and routed signals.
    input wire logic [2:0] PIN_IN_P12,
    input wire logic PIN_IN_P137, EXT_IRQ_2, EXT_IRQ_3, EXT_RESET_REQ,
    input wire logic [7:0] RD_DATA, ANALOG_IN_EN, PIN_OUT_P0, PIN_OE_P0,
    input wire logic [1:0] PIN_OE_P4
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    // High while no peripheral output is active.
    wire alt_idle = !(CLOCK_BUZZER_OUT | TIMER_OUT_CH1 | TIMER_OUT_CH2 | TIMER_OUT_CH3);

    chk_oe_follow_dir: assert property ((!RESET && $stable(DIRECTION_SELECT_P0))[*3]
        |-> PIN_OE_P0[7:1] == ~DIRECTION_SELECT_P0[7:1]) else $error("port 0 enable wrong");
    chk_p4_oe_dir: assert property ((!RESET && $stable(DIRECTION_SELECT_P4))[*3]
        |-> PIN_OE_P4 == ~DIRECTION_SELECT_P4) else $error("port 4 enable wrong");
    chk_analog_enable: assert property ((!RESET && $stable(ANALOG_DIGITAL_SELECT)
        && $stable(DIRECTION_SELECT_P0))[*3]
        |-> ANALOG_IN_EN == (ANALOG_DIGITAL_SELECT & DIRECTION_SELECT_P0))
        else $error("analog enable wrong");
    chk_irq3_route: assert property ((!RESET && PIN_REDIRECT_REG[4] && $stable(PIN_IN_P12[0]))[*4]
        |-> EXT_IRQ_3 == PIN_IN_P12[0]) else $error("irq3 not on redirected pin");
    chk_irq2_route: assert property ((!RESET && PIN_REDIRECT_REG[3] && $stable(PIN_IN_P12[1]))[*4]
        |-> EXT_IRQ_2 == PIN_IN_P12[1]) else $error("irq2 not on redirected pin");
    chk_reset_request: assert property ((!RESET && !PIN_IN_P12[2] && $stable(OPTION_BYTE))[*4]
        |-> EXT_RESET_REQ == OPTION_BYTE[4]) else $error("reset request wrong");
    chk_byte_write: assert property ((WR_EN && !WR_BIT_OP && WR_PORT == 2'h0 && alt_idle)
        ##1 (!WR_EN && alt_idle) |=> PIN_OUT_P0 == $past(WR_DATA, 2))
        else $error("port 0 latch not written");
    chk_p13_read: assert property ((!RESET && RD_PORT == 2'h3 && $stable(PIN_IN_P137))[*4]
        |-> RD_DATA == {PIN_IN_P137, 7'h00}) else $error("port 13 read wrong");
endmodule : pin_mux_properties

bind port_pin_function_mux pin_mux_properties pin_mux_properties_inst (.SYS_CLK, .RESET,
    .WR_EN, .WR_BIT_OP, .CLOCK_BUZZER_OUT, .TIMER_OUT_CH1, .TIMER_OUT_CH2, .TIMER_OUT_CH3,
    .OPTION_BYTE, .DIRECTION_SELECT_P0, .ANALOG_DIGITAL_SELECT, .PIN_REDIRECT_REG, .WR_DATA,
    .DIRECTION_SELECT_P4, .WR_PORT, .RD_PORT, .PIN_IN_P12, .PIN_IN_P137, .EXT_IRQ_2,
    .EXT_IRQ_3, .EXT_RESET_REQ, .RD_DATA, .ANALOG_IN_EN, .PIN_OUT_P0, .PIN_OE_P0, .PIN_OE_P4);

// >>> board_pins.sv
// Board model that resolves package pin levels.
`timescale 1ns/1ns

module board_pins (
    // Device drive and board levels.
    input wire logic [7:0] out_p0, oe_p0, ext_p0,
    input wire logic [1:0] out_p4, oe_p4, ext_p4,
    // Resolved pin levels.
    output logic [7:0] pin_p0,
    output logic [1:0] pin_p4
);
    // A driven pin shows the device level, a released one the board level.
    assign pin_p0 = (oe_p0 & out_p0) | (~oe_p0 & ext_p0);
    assign pin_p4 = (oe_p4 & out_p4) | (~oe_p4 & ext_p4);
endmodule : board_pins

// >>> port_pin_function_mux_test.sv
// Self-checking testbench for the port pin function multiplexer.
`timescale 1ns/1ns

module port_pin_function_mux_test;
    logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, bit_op = 1'b0, bval = 1'b0;
    logic buz = 1'b0, t1 = 1'b0, p137 = 1'b0, ti1, irq2, irq3, kr1, rreq;
    logic [7:0] opt = 8'h00, dir0 = 8'hFF, ana = 8'hFF, pin_redirect_reg = 8'h00, wdata = 8'h00;
    logic [7:0] ext0 = 8'h00, rd, pin0, out0, oe0, aen;
    logic [1:0] dir4 = 2'h3, wport = 2'h0, rport = 2'h0, ext4 = 2'h0, pin4, out4, oe4;
    logic [2:0] sel = 3'h0, p12 = 3'h7;
    int num_errors = 0, n_checks = 0;

    port_pin_function_mux port_pin_function_mux_inst (.SYS_CLK(clk), .RESET(rst),
        .OPTION_BYTE(opt), .DIRECTION_SELECT_P0(dir0), .DIRECTION_SELECT_P4(dir4),
        .ANALOG_DIGITAL_SELECT(ana), .OPEN_DRAIN_SELECT(1'b0), .PIN_REDIRECT_REG(pin_redirect_reg),
        .WR_EN(wr_en), .WR_PORT(wport), .WR_DATA(wdata), .WR_BIT_OP(bit_op),
        .WR_BIT_SEL(sel), .WR_BIT_VAL(bval), .RD_PORT(rport), .RD_DATA(rd),
        .CLOCK_BUZZER_OUT(buz), .TIMER_OUT_CH1(t1), .TIMER_OUT_CH2(1'b0),
        .TIMER_OUT_CH3(1'b0), .TIMER_IN_CH1(ti1), .EXT_IRQ_2(irq2), .EXT_IRQ_3(irq3),
        .KEY_RETURN_1(kr1), .EXT_RESET_REQ(rreq), .ANALOG_IN_EN(aen), .PIN_IN_P0(pin0),
        .PIN_IN_P4(pin4), .PIN_IN_P12(p12), .PIN_IN_P137(p137), .PIN_OUT_P0(out0),
        .PIN_OE_P0(oe0), .PIN_OUT_P4(out4), .PIN_OE_P4(oe4));
    board_pins board_pins_inst (.out_p0(out0), .oe_p0(oe0), .ext_p0(ext0), .out_p4(out4),
        .oe_p4(oe4), .ext_p4(ext4), .pin_p0(pin0), .pin_p4(pin4));

    // Free-running system clock.
    initial begin
        forever #5 clk = ~clk;
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Waits n edges, then moves just past the last one.
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // Resets the block with a given configuration byte.
    task automatic do_reset(input logic [7:0] o);
        opt = o;
        rst = 1'b1;
        step(6);
        rst = 1'b0;
    endtask : do_reset

    // Issues one port register write for a single cycle, then lets one idle edge pass.
    // The idle edge keeps back-to-back calls from raising the strobe as it is lowered.
    task automatic wr(input logic [1:0] p, input logic [7:0] d, input logic b,
                      input logic v);
        wport = p;
        wdata = d;
        bit_op = b;
        bval = v;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
        step(1);
    endtask : wr

    // Analog, digital input and output modes on port 0.
    task automatic t_modes();
        dir0 = 8'hF0;
        ana = 8'h3C;
        step(4);
        check(oe0, 8'h0F);
        check(aen, 8'h30);
    endtask : t_modes

    // Bit write reads pins of input bits and writes the whole byte back.
    task automatic t_rmw();
        dir0 = 8'hFE;
        ana = 8'h00;
        ext0 = 8'hFF;
        wr(2'h0, 8'h00, 1'b0, 1'b0);
        step(3);
        check(out0, 8'h00);
        wr(2'h0, 8'h00, 1'b1, 1'b1);
        step(4);
        check(rd, 8'hFF);
        check(out0, 8'hFF);
        ext0 = 8'hA4;
        step(4);
        check(rd, 8'hA5);
        wr(2'h0, 8'h3C, 1'b0, 1'b0);
        dir0 = 8'h00;
        wr(2'h2, 8'hFF, 1'b0, 1'b0);
        step(4);
        check(rd, 8'h3C);
    endtask : t_rmw

    // Buzzer and timer outputs move between their two pins.
    task automatic t_redirect();
        dir4 = 2'h0;
        wr(2'h0, 8'h00, 1'b0, 1'b0);
        wr(2'h1, 8'h00, 1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            pin_redirect_reg = (k == 0) ? 8'h01 : 8'h02;
            buz = (k == 0);
            t1 = (k == 1);
            step(4);
            check({4'h0, out4, out0[4], out0[2]}, 8'h04);
            pin_redirect_reg = 8'h00;
            step(4);
            check({4'h0, out4, out0[4], out0[2]}, {6'h00, k == 1, k == 0});
        end
        buz = 1'b0;
        t1 = 1'b0;
    endtask : t_redirect

    // External interrupts follow the redirection bits.
    task automatic t_irq();
        dir0 = 8'hFF;
        dir4 = 2'h3;
        ext0 = 8'h00;
        pin_redirect_reg = 8'h18;
        step(5);
        check({5'h00, ti1, irq2, irq3}, 8'h03);
        pin_redirect_reg = 8'h00;
        step(5);
        check({5'h00, ti1, irq2, irq3}, 8'h00);
        ext0 = 8'h50;
        ext4 = 2'h2;
        step(5);
        check({5'h00, ti1, irq2, irq3}, 8'h07);
        pin_redirect_reg = 8'h1A;
        p12 = 3'h4;
        step(5);
        check({5'h00, ti1, irq2, irq3}, 8'h00);
    endtask : t_irq

    // Configuration byte chooses reset input or general input.
    task automatic t_resetpin();
        p12 = 3'h3;
        rport = 2'h2;
        do_reset(8'h10);
        step(4);
        check({7'h00, rreq}, 8'h01);
        check(rd, 8'h06);
        do_reset(8'h00);
        step(4);
        check({7'h00, rreq}, 8'h00);
        p12 = 3'h7;
        step(4);
        check({7'h00, kr1}, 8'h01);
        check(rd, 8'h26);
        rport = 2'h3;
        p137 = 1'b1;
        step(5);
        check(rd, 8'h80);
    endtask : t_resetpin

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // Main sequence.
    initial begin
        do_reset(8'h00);
        t_modes();
        t_rmw();
        t_redirect();
        t_irq();
        t_resetpin();
        give_verdict();
    end

    // Watchdog against a hang.
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule : port_pin_function_mux_test
